// ---- src/index_exec.sv ----
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - load-index writes immediate into index 1,2,4,5
// - load target chosen by leading three select bits
// - code 754 is load-index, six microseconds
// - one load changes at most one index register
// - load-index address is never index-modified
// - branch if selected index positive, always decrement
// - select from select bits, decrement from auxiliary bits
// - branch decoded on six-bit code 51 alone
// - taken branch saves return, loads target addresses
// - decrement adds complemented field in index adder
// - sign sensed before the decrement is applied
// - branch takes six microseconds, no operand, unindexed
// - one minus one gives negative zero
// - address modification adds magnitude bits only
// - indexed operand address is field plus index
// - empty select bits make unconditional branch
// - index registers are seventeen bits, sign is control
// - right accumulator serves as index register three
// - index addition adds no execution time
// - select six or seven: idle, then fall through
module index_exec
    import index_exec_pkg::*;
#(
    parameter int EXEC_CYC = EXEC_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // execution status
    output logic exec_busy,
    output logic exec_done
);

    localparam int CYC_W = $clog2(EXEC_CYC + 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } exec_state_e;

    // ==========================================================
    // helpers
    function automatic logic [16:0] idx_decrement(input logic [16:0] v,
                                                  input logic [5:0] d);
        logic [15:0] dd;
        logic [16:0] diff;
        dd = {10'h000, d};
        // complement of the field added to the magnitude
        diff = 17'({1'b0, v[15:0]} + {1'b1, ~dd} + ONE_IDX);
        if (v[16]) begin
            idx_decrement = {1'b1, 16'(v[15:0] + dd)};
        end else if (!diff[16] && diff[15:0] != ADDR_RESET) begin
            idx_decrement = {1'b0, diff[15:0]};
        end else begin
            // equal values leave zero magnitude with sign set
            idx_decrement = {1'b1, 16'(~diff[15:0] + ONE_ADDR)};
        end
    endfunction : idx_decrement

    function automatic logic sel_exists(input logic [2:0] s);
        sel_exists = (s == SEL_IDX1) || (s == SEL_IDX2) || (s == SEL_RACC) ||
                     (s == SEL_IDX4) || (s == SEL_IDX5);
    endfunction : sel_exists

    function automatic logic sel_loadable(input logic [2:0] s);
        // the right accumulator is filled by other instructions
        sel_loadable = sel_exists(s) && (s != SEL_RACC);
    endfunction : sel_loadable

    // ==========================================================
    // state
    exec_state_e state;
    logic [CYC_W-1:0] cyc;
    logic [16:0] idx_file [1:5];
    logic [16:0] racc;
    logic [15:0] pc;
    logic [15:0] ret_addr;
    logic [15:0] mar;
    logic taken;

    function automatic logic [16:0] read_index(input logic [2:0] s);
        if (s == SEL_RACC) begin
            read_index = racc;
        end else if (sel_exists(s)) begin
            read_index = idx_file[s];
        end else begin
            read_index = IDX_RESET;
        end
    endfunction : read_index

    // ==========================================================
    // decode
    instr_s w;
    logic acc_phase;
    logic setup_phase;
    logic in_idx_page;
    logic addr_known;
    logic wr_refused;
    logic issue;
    logic is_load;
    logic is_branch;
    logic [5:0] decrement_field_bits;
    logic aux_class_shared_bit;
    logic [16:0] sel_val;
    logic branch_go;

    assign w = instr_s'(pwdata);
    assign acc_phase = psel && penable;
    assign setup_phase = psel && !penable;
    assign in_idx_page = (paddr[7:5] == IDX_PAGE) && sel_exists(paddr[4:2]);
    assign addr_known = (paddr[1:0] == 2'h0) &&
                        (in_idx_page || paddr == OFF_INSTR || paddr == OFF_PC ||
                         paddr == OFF_RACC || paddr == OFF_RET ||
                         paddr == OFF_MAR || paddr == OFF_STATUS);
    // state-changing writes are refused with pslverr while an instruction runs
    assign wr_refused = pwrite && (state == ST_EXEC) &&
                        (paddr == OFF_INSTR || paddr == OFF_PC || paddr == OFF_RACC);
    assign issue = acc_phase && pwrite && (paddr == OFF_INSTR) && (state == ST_IDLE);

    assign is_load = (w.opcode == OP_LOAD_INDEX);
    // only the leading six bits; the shared bit joins the decrement
    assign is_branch = (w.opcode[8:3] == OP_BRANCH_INDEX);
    assign aux_class_shared_bit = w.opcode[2];
    assign decrement_field_bits = {aux_class_shared_bit, w.opcode[1:0], w.aux_low};
    // sign is looked at on the old contents, before any write-back;
    // always_comb so that a register update also refreshes the read
    always_comb begin
        sel_val = read_index(w.index_select_bits);
    end
    assign branch_go = (w.index_select_bits == SEL_NONE) ||
                       (sel_exists(w.index_select_bits) && !sel_val[16]);

    // ==========================================================
    // apb
    assign pready = 1'b1;
    assign pslverr = acc_phase && (!addr_known || wr_refused);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase && !pwrite) begin
            if (in_idx_page) begin
                prdata <= {15'h0000, read_index(paddr[4:2])};
            end else if (paddr == OFF_PC) begin
                prdata <= {16'h0000, pc};
            end else if (paddr == OFF_RACC) begin
                prdata <= {15'h0000, racc};
            end else if (paddr == OFF_RET) begin
                prdata <= {16'h0000, ret_addr};
            end else if (paddr == OFF_MAR) begin
                prdata <= {16'h0000, mar};
            end else if (paddr == OFF_STATUS) begin
                prdata <= {30'h00000000, exec_status_s'({state == ST_EXEC, taken})};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ==========================================================
    // sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            cyc <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // load and branch each hold the unit for one slot
                    if (issue && (is_load || is_branch)) begin
                        state <= ST_EXEC;
                        cyc <= '0;
                    end
                end
                ST_EXEC: begin
                    if (cyc == CYC_W'(EXEC_CYC - 1)) begin
                        state <= ST_IDLE;
                    end else begin
                        cyc <= CYC_W'(cyc + 1'b1);
                    end
                end
            endcase
        end
    end

    assign exec_busy = (state == ST_EXEC);
    assign exec_done = (state == ST_EXEC) && (cyc == CYC_W'(EXEC_CYC - 1));

    // ==========================================================
    // index registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 1; i <= 5; i++) begin
                idx_file[i] <= IDX_RESET;
            end
        end else if (issue && is_load && sel_loadable(w.index_select_bits)) begin
            // one register only, address field taken as data
            idx_file[w.index_select_bits] <= {1'b0, w.addr};
        end else if (issue && is_branch && sel_loadable(w.index_select_bits)) begin
            idx_file[w.index_select_bits] <= idx_decrement(sel_val, decrement_field_bits);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            racc <= IDX_RESET;
        end else if (issue && is_branch && w.index_select_bits == SEL_RACC) begin
            racc <= idx_decrement(sel_val, decrement_field_bits);
        end else if (acc_phase && pwrite && paddr == OFF_RACC && !wr_refused) begin
            racc <= pwdata[16:0];
        end
    end

    // ==========================================================
    // program counter, return and memory address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= ADDR_RESET;
            ret_addr <= ADDR_RESET;
            taken <= 1'b0;
        end else if (issue) begin
            taken <= is_branch && branch_go;
            if (is_branch && branch_go) begin
                ret_addr <= 16'(pc + ONE_ADDR);
                pc <= w.addr;
            end else begin
                // select six or seven lands here too: idle slot only
                pc <= 16'(pc + ONE_ADDR);
            end
        end else if (acc_phase && pwrite && paddr == OFF_PC && !wr_refused) begin
            pc <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mar <= ADDR_RESET;
        end else if (issue) begin
            if (is_branch) begin
                if (branch_go) begin
                    mar <= w.addr;
                end
            end else if (!is_load && sel_exists(w.index_select_bits)) begin
                // magnitude only, sign never reaches the adder; done in
                // the issue cycle so indexing costs no extra time
                mar <= 16'(w.addr + sel_val[15:0]);
            end else if (!is_load) begin
                mar <= w.addr;
            end
            // load-index makes no memory reference and is never indexed
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [15:0] busy_len;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_len <= 16'h0000;
        end else if (exec_busy) begin
            busy_len <= 16'(busy_len + 1'b1);
        end else begin
            busy_len <= 16'h0000;
        end
    end

    sequence s_branch_issue;
        issue && is_branch;
    endsequence

    sequence s_load_issue;
        issue && is_load && sel_loadable(w.index_select_bits);
    endsequence

    property p_load_value;
        s_load_issue |=> idx_file[$past(w.index_select_bits)] == {1'b0, $past(w.addr)};
    endproperty
    a_load_value: assert property (p_load_value)
        else $error("load-index did not place the address field");

    property p_load_single;
        s_load_issue |=> $stable(racc) && $stable(mar) && exec_busy;
    endproperty
    a_load_single: assert property (p_load_single)
        else $error("load-index disturbed another register");

    property p_exec_length;
        $fell(exec_busy) |-> busy_len == 16'(EXEC_CYC);
    endproperty
    a_exec_length: assert property (p_exec_length)
        else $error("execution slot has the wrong length");

    property p_branch_taken;
        s_branch_issue ##0 branch_go |=> pc == $past(w.addr) && mar == $past(w.addr)
            && ret_addr == 16'($past(pc) + ONE_ADDR) && taken;
    endproperty
    a_branch_taken: assert property (p_branch_taken)
        else $error("taken branch did not move the addresses");

    property p_branch_fall;
        s_branch_issue ##0 !branch_go |=> pc == 16'($past(pc) + ONE_ADDR) && !taken
            && $stable(ret_addr);
    endproperty
    a_branch_fall: assert property (p_branch_fall)
        else $error("untaken branch did not fall through");

    property p_neg_zero;
        s_branch_issue ##0 (sel_val == ONE_IDX && decrement_field_bits == 6'h01
            && w.index_select_bits != SEL_NONE)
            |=> taken ##1 read_index($past(w.index_select_bits, 2)) == 17'h10000;
    endproperty
    a_neg_zero: assert property (p_neg_zero)
        else $error("one minus one is not negative zero");

    property p_index_add;
        issue && !is_load && !is_branch && sel_exists(w.index_select_bits)
            |=> mar == 16'($past(w.addr) + $past(sel_val[15:0])) && !exec_busy;
    endproperty
    a_index_add: assert property (p_index_add)
        else $error("operand address not field plus magnitude");

    property p_no_index;
        issue && !is_load && !is_branch && !sel_exists(w.index_select_bits)
            |=> mar == $past(w.addr);
    endproperty
    a_no_index: assert property (p_no_index)
        else $error("unindexed operand address was changed");

    property p_dead_select;
        s_branch_issue ##0 (w.index_select_bits[2:1] == 2'h3)
            |=> !taken ##1 $stable(racc) [*3];
    endproperty
    a_dead_select: assert property (p_dead_select)
        else $error("select six or seven changed state");

endmodule : index_exec

// ---- include/index_exec_pkg.sv ----
package index_exec_pkg;

    // ==========================================================
    // word layout
    localparam int ADDR_W = 16;
    localparam int IDX_W = 17;
    localparam int SEL_W = 3;
    localparam int DEC_W = 6;
    localparam int APB_AW = 8;

    // one instruction word: sign, select bits, 9-bit operation code,
    // the last three auxiliary bits, then the right half (address field)
    typedef struct packed {
        logic sign;
        logic [2:0] index_select_bits;
        logic [8:0] opcode;
        logic [2:0] aux_low;
        logic [15:0] addr;
    } instr_s;

    // register state shown to software after an issue
    typedef struct packed {
        logic busy;
        logic taken;
    } exec_status_s;

    // ==========================================================
    // operation codes
    localparam logic [8:0] OP_LOAD_INDEX = 9'h1EC;
    localparam logic [5:0] OP_BRANCH_INDEX = 6'h29;

    // ==========================================================
    // index select codes
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_IDX1 = 3'h1;
    localparam logic [2:0] SEL_IDX2 = 3'h2;
    localparam logic [2:0] SEL_RACC = 3'h3;
    localparam logic [2:0] SEL_IDX4 = 3'h4;
    localparam logic [2:0] SEL_IDX5 = 3'h5;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_PC = 8'h04;
    localparam logic [7:0] OFF_RACC = 8'h08;
    localparam logic [7:0] OFF_RET = 8'h0C;
    localparam logic [7:0] OFF_MAR = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [2:0] IDX_PAGE = 3'h1;

    localparam logic [16:0] IDX_RESET = 17'h00000;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] ONE_ADDR = 16'h0001;
    localparam logic [16:0] ONE_IDX = 17'h00001;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 40;
    localparam int EXEC_TIME_US = 6;
    localparam int EXEC_CYCLES = EXEC_TIME_US * CLK_MHZ;

endpackage : index_exec_pkg

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import index_exec_pkg::*;
    // short slot keeps the run small; every expectation uses it
    localparam int EC = 8;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic exec_busy;
    logic exec_done;
    logic [31:0] rd;
    logic er;
    logic [16:0] xm [1:5];
    logic [15:0] pc_m;
    logic [15:0] mar_m;
    int err_total;
    int n_compared;

    index_exec #(.EXEC_CYC(EC)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .exec_busy(exec_busy),
        .exec_done(exec_done)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ==========================================================
    // bus and compare helpers
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // one idle edge after each transfer so psel never flips twice in a step
    task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic rchk(input logic [APB_AW-1:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        chk($sformatf("reg %h", a), rd, e);
        chk("read error", er, 1'b0);
    endtask : rchk

    task automatic all_idx;
        for (int s = 1; s <= 5; s++) begin
            rchk(8'(8'h20 + 4 * s), {15'h0000, xm[s]});
        end
    endtask : all_idx

    // counts busy samples left after the issuing transfer
    task automatic wait_idle(input int exp);
        int nb;
        int nd;
        nb = 0;
        nd = 0;
        forever begin
            @(posedge pclk);
            if (exec_busy !== 1'b1 || nb > 1000) break;
            nb++;
            if (exec_done === 1'b1) nd++;
        end
        chk("busy cycles", nb, exp);
        chk("done pulses", nd, exp > 0);
    endtask : wait_idle

    function automatic logic [31:0] mk(logic [2:0] s, logic [11:0] opx, logic [15:0] a);
        instr_s i;
        i.sign = 1'b0;
        i.index_select_bits = s;
        {i.opcode, i.aux_low} = opx;
        i.addr = a;
        return i;
    endfunction : mk

    function automatic logic [16:0] dec_m(logic [16:0] v, logic [5:0] d);
        if (v[16]) return {1'b1, v[15:0] + 16'(d)};
        if (v[15:0] > 16'(d)) return {1'b0, v[15:0] - 16'(d)};
        return {1'b1, 16'(d) - v[15:0]};
    endfunction : dec_m

    // ==========================================================
    // instruction tasks
    task automatic ld(input logic [2:0] s, input logic [15:0] v);
        xfer(1'b1, OFF_INSTR, mk(s, {OP_LOAD_INDEX, 3'h0}, v));
        wait_idle(EC - 1);
        if (s != 3'h3) xm[s] = {1'b0, v};
        pc_m++;
        rchk(OFF_PC, pc_m);
        rchk(OFF_MAR, mar_m);
        all_idx();
    endtask : ld

    task automatic ix(input logic [2:0] s, input logic [15:0] a);
        xfer(1'b1, OFF_INSTR, mk(s, {9'h044, 3'h0}, a));
        wait_idle(0);
        mar_m = (s == 3'h0) ? a : a + xm[s][15:0];
        pc_m++;
        rchk(OFF_MAR, mar_m);
        rchk(OFF_PC, pc_m);
    endtask : ix

    task automatic br(input logic [2:0] s, input logic [5:0] d, input logic [15:0] t);
        logic tk;
        tk = (s == 3'h0) || (s <= 3'h5 && !xm[s][16]);
        xfer(1'b1, OFF_INSTR, mk(s, {OP_BRANCH_INDEX, d}, t));
        wait_idle(EC - 1);
        if (s >= 3'h1 && s <= 3'h5) xm[s] = dec_m(xm[s], d);
        rchk(OFF_STATUS, {31'h0, tk});
        if (tk) begin
            rchk(OFF_RET, pc_m + 16'h0001);
            pc_m = t;
            mar_m = t;
        end else begin
            pc_m++;
        end
        rchk(OFF_PC, pc_m);
        rchk(OFF_MAR, mar_m);
        all_idx();
    endtask : br

    // ==========================================================
    // scenarios
    task automatic t_load;
        ld(3'h1, 16'h1001);
        ld(3'h2, 16'h1002);
        ld(3'h4, 16'h1004);
        ld(3'h5, 16'h1005);
        ld(3'h3, 16'h1234);
        ld(3'h1, 16'h0003);
    endtask : t_load

    task automatic t_index;
        ix(3'h2, 16'h0200);
        ix(3'h0, 16'h0300);
        xfer(1'b1, OFF_RACC, 32'h00000005);
        xm[3] = 17'h00005;
        ix(3'h3, 16'h0010);
        xfer(1'b1, OFF_RACC, 32'h00010007);
        xm[3] = 17'h10007;
        ix(3'h3, 16'h0010);
    endtask : t_index

    task automatic t_branch;
        repeat (3) br(3'h1, 6'h01, 16'h0050);
        ix(3'h1, 16'h0400);
        br(3'h1, 6'h01, 16'h0050);
        br(3'h2, 6'h2A, 16'h0060);
        br(3'h4, 6'h3F, 16'h0070);
        br(3'h3, 6'h01, 16'h0080);
        br(3'h0, 6'h00, 16'h0777);
        br(3'h6, 6'h01, 16'h0111);
        br(3'h7, 6'h01, 16'h0122);
    endtask : t_branch

    task automatic t_refuse;
        xfer(1'b1, OFF_INSTR, mk(3'h5, {OP_LOAD_INDEX, 3'h0}, 16'h0055));
        xfer(1'b1, OFF_INSTR, mk(3'h5, {OP_LOAD_INDEX, 3'h0}, 16'h0066));
        chk("busy write error", er, 1'b1);
        rchk(OFF_STATUS, 32'h00000002);
        wait_idle(EC - 7);
        xm[5] = 17'h00055;
        pc_m++;
        all_idx();
        rchk(OFF_PC, pc_m);
        xfer(1'b0, 8'h40, 32'h00000000);
        chk("unmapped data", rd, 32'h00000000);
        chk("unmapped error", er, 1'b1);
        xfer(1'b1, 8'h41, 32'h00000001);
        chk("misaligned error", er, 1'b1);
    endtask : t_refuse

    task automatic end_sim;
        $display("mismatches %0d of %0d compared", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // ==========================================================
    // main sequence and watchdog
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        err_total = 0;
        n_compared = 0;
        for (int s = 1; s <= 5; s++) xm[s] = 17'h00000;
        pc_m = 16'h0000;
        mar_m = 16'h0000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        all_idx();
        rchk(OFF_STATUS, 32'h00000000);
        xfer(1'b1, OFF_PC, 32'h00000100);
        pc_m = 16'h0100;
        t_load();
        t_index();
        t_branch();
        t_refuse();
        end_sim();
    end

    // whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        end_sim();
    end
endmodule : testbench
